// ==== core/pil_pkg.sv ====
package pil_pkg;
    // Register word offsets (byte addresses, index * 4)
    localparam logic [3:0] PIL_OFS_FLAGS = 4'h0;
    localparam logic [3:0] PIL_OFS_ENABLES = 4'h4;
    localparam logic [3:0] PIL_OFS_SHIFTER = 4'h8;
    localparam logic [3:0] PIL_OFS_CTRL = 4'hc;
    localparam logic [4:0] PIL_OFS_EVENTS = 5'h10;
    // Field positions
    localparam int PIL_SUMMARY_BIT = 7;
    localparam int PIL_SHIFT_FLAG_BIT = 2;
    localparam int PIL_CTRL_MODE_LSB = 0;
    // Reset values
    localparam logic [6:0] PIL_FLAGS_RST = 7'h00;
    localparam logic [6:0] PIL_ENABLES_RST = 7'h00;
    localparam logic [7:0] PIL_SHIFTER_RST = 8'h00;
    localparam logic [2:0] PIL_MODE_RST = 3'h0;
    // Shift mode with external shift clock
    localparam logic [2:0] PIL_MODE_EXT_OUT = 3'h7;
    localparam logic [3:0] PIL_BITS_PER_BYTE = 4'h8;
    // Unmapped read answer
    localparam logic [31:0] PIL_UNMAPPED_DATA = 32'h0000_0000;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } pil_bus_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } pil_bus_rsp_t;
endpackage : pil_pkg

// ==== core/pil_fifo.sv ====
`timescale 1ns/1ps
module pil_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : pil_fifo

// ==== core/pil_top.sv ====
`timescale 1ns/1ps
module pil_top #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Other flag sources
    input wire logic [6:0] flag_events,
    // Serial pins
    input wire logic shift_clock_pin,
    output logic shift_data_pin_o,
    output logic shift_data_pin_oe,
    // Interrupt request, open drain
    output logic irq_n_o,
    output logic irq_n_oe
);
    import pil_pkg::*;

    typedef enum logic [1:0] {PIL_IDLE, PIL_ANSWER} pil_bus_state_t;

    pil_bus_req_t req;
    pil_bus_state_t bus_q;
    logic [6:0] flags_q;
    logic [6:0] enables_q;
    logic [7:0] shifter_q;
    logic [2:0] mode_q;
    logic [3:0] count_q;
    logic counting_q;
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic sclk_s3_q;
    logic shift_pulse;
    logic ext_mode;
    logic take;
    logic hit_flags;
    logic hit_enables;
    logic hit_shifter;
    logic hit_ctrl;
    logic shifter_access;
    logic byte_done;
    logic load_valid;
    logic load_ready;
    logic [7:0] load_data;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic [6:0] active;

    assign req = '{address: avs_address, read: avs_read,
                   write: avs_write, writedata: avs_writedata,
                   byteenable: avs_byteenable};
    assign ext_mode = (mode_q == PIL_MODE_EXT_OUT);
    assign take = (bus_q == PIL_ANSWER);
    assign hit_flags = ({req.address[4:2], 2'b00} == 5'(PIL_OFS_FLAGS));
    assign hit_enables = ({req.address[4:2], 2'b00} == 5'(PIL_OFS_ENABLES));
    assign hit_shifter = ({req.address[4:2], 2'b00} == 5'(PIL_OFS_SHIFTER));
    assign hit_ctrl = ({req.address[4:2], 2'b00} == 5'(PIL_OFS_CTRL));
    assign shifter_access = take && hit_shifter && (req.read || req.write);
    assign active = flags_q & enables_q;

    // Bus handshake: one wait cycle, answer on second edge
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_q <= PIL_IDLE;
        end else begin
            case (bus_q)
                PIL_IDLE: begin
                    if (req.read || req.write) begin
                        bus_q <= PIL_ANSWER;
                    end
                end
                PIL_ANSWER: begin
                    bus_q <= PIL_IDLE;
                end
                default: begin
                    bus_q <= PIL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((bus_q == PIL_IDLE)
                && (req.read || req.write));
        end
    end

    // Read data
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_readdata <= PIL_UNMAPPED_DATA;
        end else if ((bus_q == PIL_IDLE) && req.read) begin
            if (hit_flags) begin
                avs_readdata <= {24'h0, |active, flags_q};
            end else if (hit_enables) begin
                avs_readdata <= {24'h0, 1'b1, enables_q};
            end else if (hit_shifter) begin
                avs_readdata <= {24'h0, shifter_q};
            end else if (hit_ctrl) begin
                avs_readdata <= {29'h0, mode_q};
            end else begin
                avs_readdata <= PIL_UNMAPPED_DATA;
            end
        end
    end

    // Shift clock synchroniser and rising edge
    // A fast clock samples the pin every cycle, covering the low phase
    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
        end else begin
            sclk_s1_q <= shift_clock_pin;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
        end
    end
    assign shift_pulse = ext_mode && sclk_s2_q && !sclk_s3_q;

    // Mode register
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= PIL_MODE_RST;
        end else if (take && req.write && hit_ctrl && req.byteenable[0]) begin
            mode_q <= req.writedata[PIL_CTRL_MODE_LSB +: 3];
        end
    end

    // Shifter loads go through the FIFO so bytes queue ahead of shifting
    assign load_valid = take && req.write && hit_shifter
        && req.byteenable[0];
    assign load_data = req.writedata[7:0];
    assign fifo_pop = fifo_out_valid && (byte_done || !counting_q);

    pil_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(load_valid),
        .in_ready(load_ready),
        .in_data(load_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Bit counter; free-running over bytes in mode 7
    assign byte_done = shift_pulse && (count_q == PIL_BITS_PER_BYTE - 4'h1);
    always_ff @(posedge clock) begin
        if (rst) begin
            count_q <= 4'h0;
        end else if (shifter_access) begin
            count_q <= 4'h0;
        end else if (shift_pulse) begin
            count_q <= byte_done ? 4'h0 : count_q + 4'h1;
        end
    end

    // Shifter holds a fresh byte until its last bit leaves
    always_ff @(posedge clock) begin
        if (rst) begin
            counting_q <= 1'b0;
        end else if (fifo_pop) begin
            counting_q <= 1'b1;
        end else if (byte_done) begin
            counting_q <= 1'b0;
        end
    end

    // Shifter: MSB out, recirculated, next byte taken at boundary
    always_ff @(posedge clock) begin
        if (rst) begin
            shifter_q <= PIL_SHIFTER_RST;
        end else if (fifo_pop) begin
            shifter_q <= fifo_out_data;
        end else if (shift_pulse) begin
            shifter_q <= {shifter_q[6:0], shifter_q[7]};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            shift_data_pin_o <= 1'b0;
            shift_data_pin_oe <= 1'b0;
        end else begin
            shift_data_pin_oe <= ext_mode;
            if (shift_pulse) begin
                shift_data_pin_o <= shifter_q[7];
            end
        end
    end

    // Flags: set wins over clear
    always_ff @(posedge clock) begin
        if (rst) begin
            flags_q <= PIL_FLAGS_RST;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (flag_events[i] ||
                    (i == PIL_SHIFT_FLAG_BIT && byte_done)) begin
                    flags_q[i] <= 1'b1;
                end else if (i == PIL_SHIFT_FLAG_BIT && shifter_access) begin
                    flags_q[i] <= 1'b0;
                end else if (take && req.write && hit_flags
                             && req.byteenable[0] && req.writedata[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    end

    // Enables: bit 7 picks set or clear
    always_ff @(posedge clock) begin
        if (rst) begin
            enables_q <= PIL_ENABLES_RST;
        end else if (take && req.write && hit_enables && req.byteenable[0]) begin
            if (req.writedata[PIL_SUMMARY_BIT]) begin
                enables_q <= enables_q | req.writedata[6:0];
            end else begin
                enables_q <= enables_q & ~req.writedata[6:0];
            end
        end
    end

    // Open-drain request, driven low while any enabled flag is set
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_n_o <= 1'b0;
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_o <= 1'b0;
            irq_n_oe <= |active;
        end
    end
endmodule : pil_top

// ==== test/pil_top_properties.sv ====
`timescale 1ns/1ps
module pil_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins
    input wire logic shift_data_pin_oe,
    input wire logic irq_n_oe
);
    logic off_q;
    logic en_wr;
    logic ack;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    assign ack = !avs_waitrequest;
    assign en_wr = avs_write && ack && avs_byteenable[0]
        && avs_address[4:2] == 3'h1;
    // Enables known all clear
    always_ff @(posedge clock) begin
        if (rst) begin
            off_q <= 1'b1;
        end else if (en_wr) begin
            off_q <= !avs_writedata[7]
                && (off_q || avs_writedata[6:0] == 7'h7f);
        end
    end
    chk_wait_one: assert property ((avs_read || avs_write) && !ack
        |=> ack) else $error("bus answer late");
    chk_wait_pulse: assert property (ack |=> !ack)
        else $error("wait low too long");
    chk_en_bit7: assert property (avs_read && ack && avs_address[4:2] == 3'h1
        |-> avs_readdata[7]) else $error("enable bit7 not one");
    chk_upper_zero: assert property (avs_read && ack
        |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
    chk_rst_irq: assert property ($fell(rst) |-> !irq_n_oe)
        else $error("request after reset");
    chk_rst_oe: assert property ($fell(rst) |-> !shift_data_pin_oe)
        else $error("data pin driven after reset");
    chk_irq_masked: assert property (off_q && $past(off_q, 2)
        |-> !irq_n_oe) else $error("request while all disabled");
    chk_sum_masked: assert property (avs_read && ack && avs_address[4:2] == 3'h0
        && off_q && $past(off_q, 3) |-> !avs_readdata[7])
        else $error("summary set while all disabled");
    cov_irq: cover property (irq_n_oe);
    cov_en_wr: cover property (en_wr);
    cov_shift: cover property (shift_data_pin_oe);
endmodule : pil_chk
bind pil_top pil_chk u_chk (.clock, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .shift_data_pin_oe, .irq_n_oe);

// ==== test/pil_shift_dev.sv ====
`timescale 1ns/1ps
module pil_shift_dev (
    // Clock
    input wire logic clock,
    // Shift clock out
    output logic shift_clock_pin
);
    // Idle low outside frames
    initial shift_clock_pin = 1'b0;
    // One pulse, high four clocks then low four
    task automatic pulse;
        @(posedge clock);
        shift_clock_pin <= 1'b1;
        repeat (4) @(posedge clock);
        shift_clock_pin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : pulse
endmodule : pil_shift_dev

// ==== test/peripheral_interrupt_logic_tb.sv ====
`timescale 1ns/1ps
module peripheral_interrupt_logic_tb;
    localparam logic [4:0] FL = 5'h00, EN = 5'h04, SH = 5'h08;
    localparam logic [4:0] CT = 5'h0c, UM = 5'h14;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [6:0] flag_events = 7'h00;
    logic shift_clock_pin;
    logic shift_data_pin_o;
    logic shift_data_pin_oe;
    logic irq_n_oe;
    logic irq_n_o;
    logic [31:0] rd;
    logic [7:0] sb = 8'ha5;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #20 clock = ~clock;
    pil_top #(.FIFO_DEPTH(4)) uut (.clock, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .flag_events, .shift_clock_pin,
        .shift_data_pin_o, .shift_data_pin_oe, .irq_n_o, .irq_n_oe);
    pil_shift_dev dev (.clock, .shift_clock_pin);
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [4:0] a,
            input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rchk
    always @(posedge clock) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rchk(FL, 32'h00);
        rchk(EN, 32'h80);
        rchk(UM, 32'h00);
        $display("test reset done");
        bus(1'b1, EN, 32'h95);
        rchk(EN, 32'h95);
        bus(1'b1, EN, 32'h11);
        rchk(EN, 32'h84);
        $display("test enables done");
        flag_events <= 7'h10;
        @(posedge clock);
        flag_events <= 7'h00;
        rchk(FL, 32'h10);
        check({31'h0, irq_n_oe}, 32'h0);
        bus(1'b1, EN, 32'h90);
        rchk(FL, 32'h90);
        check({31'h0, irq_n_oe}, 32'h1);
        check({31'h0, irq_n_o}, 32'h0);
        bus(1'b1, FL, 32'h80);
        rchk(FL, 32'h90);
        bus(1'b1, FL, 32'h10);
        rchk(FL, 32'h00);
        check({31'h0, irq_n_oe}, 32'h0);
        flag_events <= 7'h41;
        @(posedge clock);
        flag_events <= 7'h00;
        rchk(FL, 32'h41);
        bus(1'b1, FL, 32'h40);
        rchk(FL, 32'h01);
        bus(1'b1, FL, 32'h01);
        rchk(FL, 32'h00);
        $display("test flags done");
        bus(1'b1, CT, 32'h7);
        @(posedge clock);
        check({31'h0, shift_data_pin_oe}, 32'h1);
        rchk(CT, 32'h07);
        bus(1'b1, SH, {24'h0, sb});
        for (int k = 0; k < 9; k++) begin
            dev.pulse();
            check({31'h0, shift_data_pin_o}, {31'h0, sb[7 - k % 8]});
            if (k == 6) rchk(FL, 32'h00);
            if (k == 7) rchk(FL, 32'h84);
        end
        rchk(FL, 32'h84);
        check({31'h0, irq_n_oe}, 32'h1);
        bus(1'b1, EN, 32'h7f);
        rchk(FL, 32'h04);
        check({31'h0, irq_n_oe}, 32'h0);
        bus(1'b0, SH, 32'h0);
        rchk(FL, 32'h00);
        for (int k = 0; k < 8; k++) begin
            dev.pulse();
            if (k == 6) rchk(FL, 32'h00);
        end
        rchk(FL, 32'h04);
        $display("test shifter done");
        give_verdict();
    end
endmodule : peripheral_interrupt_logic_tb
